/* rtl/sldpe_engine.sv */
// Purpose: Packet layer and command interpreter of a serial boot loader.
// Assumes: Received bytes arrive one per RX_VALID pulse; TX_READY paces output.
// Notes: Memory writes are issued as PROG strobes; erase is a timed request.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RQ1: First byte is packet length including length and sum bytes.
// RQ2: Second byte equals the sum of data bytes only.
// RQ3: Sum keeps only the low eight bits.
// RQ4: Answer each packet with 0xCC on success, 0x33 on failure.
// RQ5: A sum mismatch is a faulty packet and gets 0x33.
// RQ6: Acknowledge means good reception, not a valid command.
// RQ7: Zeros may precede a returned packet; first nonzero is its length.
// RQ8: Returned packet bytes follow each other without gaps.
// RQ9: Host answers each returned packet with acknowledge or negative.
// RQ10: After a negative answer the host resends the failed command.
// RQ11: While waiting for the host answer, zero bytes are ignored.
// RQ12: Synchronous host clocks data out with zero padding bytes.
// RQ13: First data byte is the command code.
// RQ14: Ping 0x20 sets status to success.
// RQ15: Query 0x23 returns one status byte in a packet.
// RQ16: Download 0x21 carries address then count, most significant first.
// RQ17: Download erases the region before answering.
// RQ18: Data 0x24 valid only after download; programs and advances address.
// RQ19: Host puts at most eight data bytes in a data command.
// RQ20: Programming stops once the download count is reached.
// RQ21: A rejected data packet leaves the address unchanged.
// RQ22: Host queries status after download and data commands.
// RQ23: Run 0x22 carries an address; acknowledge precedes the jump.
// RQ24: Reset 0x25 acknowledges first, then resets the device.
module sldpe_engine
	import sldpe_pkg::*;
#(
	parameter int ERASE_WAIT = ERASE_CYCLES
) (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic NRST,
	// Received byte stream.
	input wire sldpe_pkg::sldpe_byte_s RX,
	// Transmit byte stream.
	output sldpe_pkg::sldpe_byte_s TX,
	input wire logic TX_READY,
	// Target memory side.
	output sldpe_pkg::sldpe_prog_s PROG,
	output logic PROG_STROBE,
	output logic ERASE_STROBE,
	output logic [31:0] ERASE_ADDR,
	output logic [31:0] ERASE_LEN,
	// Execution control.
	output logic RUN_STROBE,
	output logic [31:0] RUN_ADDR,
	output logic SOFT_RESET
);
	import sldpe_pkg::*;

	typedef enum logic [2:0] {
		S_LEN = 3'b000,
		S_SUM = 3'b001,
		S_DATA = 3'b010,
		S_EXEC = 3'b011,
		S_ERASE = 3'b100,
		S_ANSWER = 3'b101,
		S_REPLY = 3'b110,
		S_WAIT_HOST = 3'b111
	} sldpe_state_e;

	sldpe_state_e state;
	logic [7:0] pkt_len;
	logic [7:0] pkt_sum;
	logic [7:0] idx;
	logic [7:0] cmd;
	logic [63:0] params;
	logic [7:0] dbuf [0:7];
	logic [7:0] status;
	logic [31:0] prog_addr;
	logic [31:0] prog_left;
	logic armed;
	logic good;
	logic [1:0] reply_idx;
	logic [3:0] wr_idx;
	logic pend_run;
	logic pend_reset;
	logic [7:0] calc_sum;
	logic erase_done;
	logic sum_clear;
	logic sum_add;
	logic rx_byte;
	logic ack_out;

	assign rx_byte = RX.valid;
	assign sum_clear = (state == S_LEN);
	assign sum_add = rx_byte && (state == S_DATA);

	// Sum of data bytes only; the length and sum bytes never enter it.
	sldpe_sum u_sum (
		.clk(CLOCK),
		.nrst(NRST),
		.clear(sum_clear), // RQ2
		.add(sum_add),
		.data(RX.data),
		.sum(calc_sum)
	);

	sldpe_timer #(.CYCLES(ERASE_WAIT)) u_erase (
		.clk(CLOCK),
		.nrst(NRST),
		.start(ERASE_STROBE),
		.done(erase_done)
	);

	// Assemble big-endian 32-bit words from the parameter bytes.
	function automatic logic [31:0] word_at(input logic [63:0] p, input logic hi);
		word_at = hi ? p[63:32] : p[31:0];
	endfunction

	// ********************************
	// Packet receive and command state machine
	// ********************************
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			state <= S_LEN;
			pkt_len <= 8'h00;
			pkt_sum <= 8'h00;
			idx <= 8'h00;
			cmd <= 8'h00;
			params <= 64'h0;
			good <= 1'b0;
			reply_idx <= 2'b00;
		end else begin
			unique case (state)
				S_LEN: begin
					// Leading zeros are padding, not a length.
					if (rx_byte && RX.data != 8'h00) begin
						pkt_len <= RX.data; // RQ1
						state <= S_SUM;
					end
				end
				S_SUM: begin
					if (rx_byte) begin
						pkt_sum <= RX.data;
						idx <= 8'h00;
						cmd <= 8'h00; // A short packet must not replay the last command.
						state <= (pkt_len > HDR_BYTES) ? S_DATA : S_EXEC;
					end
				end
				S_DATA: begin
					if (rx_byte) begin
						if (idx == 8'h00) begin
							cmd <= RX.data; // RQ13
						end else begin
							params <= {params[55:0], RX.data}; // RQ16
						end
						idx <= idx + 8'h01;
						if (idx == pkt_len - HDR_BYTES - 8'h01) begin // RQ1
							state <= S_EXEC;
						end
					end
				end
				S_EXEC: begin
					good <= (calc_sum == pkt_sum); // RQ5
					if (calc_sum == pkt_sum && cmd == CMD_DOWNLOAD && pkt_len == LEN_LONG) begin
						state <= S_ERASE; // RQ17
					end else begin
						state <= S_ANSWER;
					end
				end
				S_ERASE: begin
					if (erase_done) begin
						state <= S_ANSWER;
					end
				end
				S_ANSWER: begin
					if (TX_READY) begin
						reply_idx <= 2'b00;
						state <= (good && cmd == CMD_QUERY_RESULT) ? S_REPLY : S_LEN; // RQ15
					end
				end
				S_REPLY: begin
					// Three bytes back to back once the acknowledge byte leaves.
					if (TX_READY) begin
						reply_idx <= reply_idx + 2'b01;
						if (reply_idx == 2'b10) begin
							state <= S_WAIT_HOST; // RQ8
						end
					end
				end
				S_WAIT_HOST: begin
					if (rx_byte && RX.data != 8'h00) begin
						state <= S_LEN; // RQ11
					end
				end
			endcase
		end
	end

	// ********************************
	// Transmit byte
	// ********************************
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			TX <= '0;
			ack_out <= 1'b0;
		end else begin
			TX.valid <= 1'b0;
			// High while an acknowledge byte stands on TX, so later strobes can follow it.
			ack_out <= state == S_ANSWER && TX_READY && good;
			if (state == S_ANSWER && TX_READY) begin
				TX <= '{valid: 1'b1, data: good ? ACK_BYTE : NAK_BYTE}; // RQ4 RQ6
			end else if (state == S_REPLY && TX_READY) begin
				unique case (reply_idx)
					2'b00: TX <= '{valid: 1'b1, data: LEN_SHORT}; // RQ7
					2'b01: TX <= '{valid: 1'b1, data: status}; // RQ15
					default: TX <= '{valid: 1'b1, data: status};
				endcase
			end
		end
	end

	// ********************************
	// Command effects and status
	// ********************************
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			status <= STAT_SUCCESS;
			prog_addr <= 32'h0;
			prog_left <= 32'h0;
			armed <= 1'b0;
			ERASE_STROBE <= 1'b0;
			ERASE_ADDR <= 32'h0;
			ERASE_LEN <= 32'h0;
			wr_idx <= 4'h0;
			pend_run <= 1'b0;
			pend_reset <= 1'b0;
			RUN_ADDR <= 32'h0;
		end else begin
			ERASE_STROBE <= 1'b0;
			if (state == S_EXEC && calc_sum == pkt_sum) begin
				wr_idx <= 4'h0;
				unique case (cmd)
					CMD_PING: status <= STAT_SUCCESS; // RQ14
					CMD_QUERY_RESULT: status <= status;
					CMD_DOWNLOAD: begin
						if (pkt_len == LEN_LONG) begin
							prog_addr <= word_at(params, 1'b1); // RQ16
							prog_left <= word_at(params, 1'b0);
							ERASE_ADDR <= word_at(params, 1'b1);
							ERASE_LEN <= word_at(params, 1'b0);
							ERASE_STROBE <= 1'b1; // RQ17
							armed <= 1'b1;
							status <= STAT_SUCCESS;
						end else begin
							status <= STAT_INVALID_CMD;
						end
					end
					CMD_SEND_DATA: begin
						if (!armed || pkt_len <= 8'h03 || pkt_len - 8'h03 > MAX_DATA_BYTES) begin
							status <= STAT_INVALID_CMD; // RQ18
						end else begin
							wr_idx <= 4'(pkt_len - 8'h03);
							status <= STAT_SUCCESS;
						end
					end
					CMD_RUN: begin
						if (pkt_len == LEN_RUN) begin
							RUN_ADDR <= word_at(params, 1'b0);
							pend_run <= 1'b1; // RQ23
							status <= STAT_SUCCESS;
						end else begin
							status <= STAT_INVALID_CMD;
						end
					end
					CMD_RESET: pend_reset <= (pkt_len == LEN_SHORT); // RQ24
					default: status <= STAT_UNKNOWN_CMD;
				endcase
			end else if (wr_idx != 4'h0) begin
				// One byte per cycle; the address only moves on a good packet.
				wr_idx <= wr_idx - 4'h1;
				if (prog_left != 32'h0) begin
					prog_addr <= prog_addr + 32'h1; // RQ18 RQ21
					prog_left <= prog_left - 32'h1; // RQ20
				end else begin
					armed <= 1'b0; // RQ20
				end
			end
			if (ack_out) begin
				pend_run <= 1'b0;
				pend_reset <= 1'b0;
			end
		end
	end

	// Capture data bytes so the programming pass can walk them later.
	always_ff @(posedge CLOCK) begin
		if (rx_byte && state == S_DATA && idx != 8'h00 && idx <= MAX_DATA_BYTES) begin
			dbuf[3'(idx - 8'h01)] <= RX.data;
		end
	end

	// ********************************
	// Output strobes
	// ********************************
	always_ff @(posedge CLOCK) begin
		if (!NRST) begin
			PROG <= '0;
			PROG_STROBE <= 1'b0;
			RUN_STROBE <= 1'b0;
			SOFT_RESET <= 1'b0;
		end else begin
			PROG_STROBE <= (wr_idx != 4'h0) && (prog_left != 32'h0) && state != S_EXEC;
			PROG.addr <= prog_addr;
			PROG.data <= dbuf[3'(pkt_len - 8'h03 - {4'h0, wr_idx})];
			// Run and reset fire only after their acknowledge byte left.
			RUN_STROBE <= ack_out && pend_run; // RQ23
			SOFT_RESET <= ack_out && pend_reset; // RQ24
		end
	end

	// ********************************
	// Checks
	// ********************************
	property p_ack_code;
		@(posedge CLOCK) disable iff (!NRST)
		(state == S_ANSWER && TX_READY) |=> TX.valid && (TX.data == ACK_BYTE || TX.data == NAK_BYTE);
	endproperty
	a_ack_code: assert property (p_ack_code) else $error("Answer byte is not ACK or NAK."); // RQ4

	property p_bad_sum;
		@(posedge CLOCK) disable iff (!NRST)
		(state == S_EXEC && calc_sum != pkt_sum) |=> ##[1:300] (TX.valid && TX.data == NAK_BYTE);
	endproperty
	a_bad_sum: assert property (p_bad_sum) else $error("Bad sum not refused."); // RQ5

	property p_erase_first;
		@(posedge CLOCK) disable iff (!NRST)
		ERASE_STROBE |-> state == S_ERASE;
	endproperty
	a_erase_first: assert property (p_erase_first) else $error("Erase not holding answer."); // RQ17

	property p_run_after_ack;
		@(posedge CLOCK) disable iff (!NRST)
		RUN_STROBE |-> $past(TX.valid && TX.data == ACK_BYTE);
	endproperty
	a_run_after_ack: assert property (p_run_after_ack) else $error("Run without ACK."); // RQ23

	property p_reset_after_ack;
		@(posedge CLOCK) disable iff (!NRST)
		SOFT_RESET |-> $past(TX.valid && TX.data == ACK_BYTE);
	endproperty
	a_reset_after_ack: assert property (p_reset_after_ack) else $error("Reset without ACK."); // RQ24

	property p_nak_keeps_addr;
		@(posedge CLOCK) disable iff (!NRST)
		(state == S_EXEC && calc_sum != pkt_sum) |=> $stable(prog_addr);
	endproperty
	a_nak_keeps_addr: assert property (p_nak_keeps_addr) else $error("Address moved on NAK."); // RQ21

	property p_stop_at_count;
		@(posedge CLOCK) disable iff (!NRST)
		(prog_left == 32'h0) |=> !PROG_STROBE;
	endproperty
	a_stop_at_count: assert property (p_stop_at_count) else $error("Write past count."); // RQ20

	property p_ping_status;
		@(posedge CLOCK) disable iff (!NRST)
		(state == S_EXEC && calc_sum == pkt_sum && cmd == CMD_PING) |=> status == STAT_SUCCESS;
	endproperty
	a_ping_status: assert property (p_ping_status) else $error("Ping left status wrong."); // RQ14

	// Every reply slot the link grants must carry a byte; ready is taken one edge before TX shows.
	sequence s_reply_slot;
		state == S_REPLY && TX_READY;
	endsequence
	property p_reply_contig;
		@(posedge CLOCK) disable iff (!NRST)
		s_reply_slot |=> TX.valid;
	endproperty
	a_reply_contig: assert property (p_reply_contig) else $error("Gap in reply."); // RQ8
endmodule
`default_nettype wire

/* rtl/sldpe_pkg.sv */
// Purpose: Shared constants and carriers for the serial loader packet engine.
// Assumes: Byte-wide serial link framing is done outside this block.
// Notes: All codes, lengths and timing counts live here.
package sldpe_pkg;

	// ********************************
	// Link bytes and command codes
	// ********************************
	localparam logic [7:0] ACK_BYTE = 8'hCC;
	localparam logic [7:0] NAK_BYTE = 8'h33;
	localparam logic [7:0] CMD_PING = 8'h20;
	localparam logic [7:0] CMD_DOWNLOAD = 8'h21;
	localparam logic [7:0] CMD_RUN = 8'h22;
	localparam logic [7:0] CMD_QUERY_RESULT = 8'h23;
	localparam logic [7:0] CMD_SEND_DATA = 8'h24;
	localparam logic [7:0] CMD_RESET = 8'h25;

	// ********************************
	// Packet lengths and status codes
	// ********************************
	localparam logic [7:0] LEN_SHORT = 8'h03;
	localparam logic [7:0] LEN_RUN = 8'h07;
	localparam logic [7:0] LEN_LONG = 8'h0B;
	localparam logic [7:0] HDR_BYTES = 8'h02;
	localparam logic [7:0] MAX_DATA_BYTES = 8'h08;
	localparam logic [7:0] STAT_SUCCESS = 8'h40;
	localparam logic [7:0] STAT_UNKNOWN_CMD = 8'h41;
	localparam logic [7:0] STAT_INVALID_CMD = 8'h42;
	localparam logic [7:0] STAT_FLASH_FAIL = 8'h43;

	// ********************************
	// Timing
	// ********************************
	localparam int CLK_MHZ = 50;
	localparam int ERASE_US = 100;
	localparam int ERASE_CYCLES = ERASE_US * CLK_MHZ;

	// One byte moving across the link.
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sldpe_byte_s;

	// One byte written into target memory.
	typedef struct packed {
		logic [31:0] addr;
		logic [7:0] data;
	} sldpe_prog_s;

endpackage

/* rtl/sldpe_sum.sv */
// Purpose: Eight-bit running sum of packet data bytes.
// Assumes: clear and add never needed in the same byte slot with stale data.
// Notes: Carries above bit 7 are dropped.
`timescale 1ns/1ps
`default_nettype none
module sldpe_sum (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Control.
	input wire logic clear,
	input wire logic add,
	input wire logic [7:0] data,
	// Result.
	output logic [7:0] sum
);
	// Clear wins over add, since a fresh packet always starts from zero.
	always_ff @(posedge clk) begin
		if (!nrst || clear) begin
			sum <= 8'h00;
		end else if (add) begin
			sum <= sum + data; // RQ3
		end
	end
endmodule
`default_nettype wire

/* rtl/sldpe_timer.sv */
// Purpose: Down counter that holds the engine while an erase runs.
// Assumes: start is a one-cycle pulse.
// Notes: done is a one-cycle pulse at the end of the count.
`timescale 1ns/1ps
`default_nettype none
module sldpe_timer #(
	parameter int CYCLES = 5000
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Control.
	input wire logic start,
	output logic done
);
	logic [31:0] count;

	// Count down from the load value; done fires as it reaches zero.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			count <= 32'h0000_0000;
			done <= 1'b0;
		end else begin
			done <= (count == 32'h0000_0001);
			if (start) begin
				count <= 32'(CYCLES);
			end else if (count != 32'h0000_0000) begin
				count <= count - 32'h0000_0001;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/sldpe_host.sv */
// Purpose: Host side model that frames packets and reads the engine's answers.
// Assumes: One byte is offered to the engine every two clocks.
// Notes: Slow mode drops TX_READY on every other cycle.
`timescale 1ns/1ps
`default_nettype none
module sldpe_host
	import sldpe_pkg::*;
(
	// Link towards the engine.
	input wire logic clk,
	output sldpe_pkg::sldpe_byte_s rx,
	input wire sldpe_pkg::sldpe_byte_s tx,
	output logic tx_ready
);
	import sldpe_pkg::*;
	logic slow = 1'b0;
	logic [7:0] got[$];
	time tq[$];

	// Idle line and a ready link at time zero.
	initial begin
		rx = '{1'b0, 8'h00};
		tx_ready = 1'b1;
	end

	// Pacing; a stalling link tests that the engine waits for ready.
	always @(posedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;

	// Every byte from the engine is queued with its time.
	always @(posedge clk) begin
		if (tx.valid === 1'b1) begin
			got.push_back(tx.data);
			tq.push_back($time);
		end
	end

	// One byte; afterwards the data shows its inverse so nothing stale looks valid.
	task send(input logic [7:0] b);
		@(posedge clk);
		rx <= '{1'b1, b};
		@(posedge clk);
		rx <= '{1'b0, ~b};
	endtask

	// A nonzero bad value corrupts the sum on purpose.
	task pkt(input logic [7:0] d[$], input logic [7:0] bad);
		logic [7:0] s;
		s = bad;
		foreach (d[i]) s = s + d[i];
		send(8'(d.size() + 2));
		send(s);
		foreach (d[i]) send(d[i]);
	endtask

	// Zero padding is skipped; the first nonzero byte is taken.
	task get(output logic [7:0] b, output time t);
		int n;
		n = 0;
		b = 8'h00;
		t = 0;
		while (b == 8'h00 && n < 400) begin
			if (got.size() > 0) begin
				b = got.pop_front();
				t = tq.pop_front();
			end else begin
				@(posedge clk);
				n++;
			end
		end
	endtask

	// Reply to a returned packet after one padding byte.
	task answer(input logic [7:0] b);
		send(8'h00);
		send(b);
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the serial loader packet engine.
// Assumes: Erase wait is cut to a few cycles.
// Notes: Programmed bytes and strobes are collected by a monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sldpe_pkg::*;
	localparam int EW = 4;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	sldpe_byte_s rx;
	sldpe_byte_s tx;
	sldpe_prog_s prog;
	logic tx_ready, prog_strobe, erase_strobe, run_strobe, soft_reset;
	logic [31:0] erase_addr, erase_len, run_addr;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	sldpe_prog_s pq[$];
	time er_t = 0;
	time run_t = 0;
	time sr_t = 0;
	time t;
	logic [7:0] b;

	always #10 clock = ~clock;

	sldpe_engine #(.ERASE_WAIT(EW)) i_sldpe_engine (.CLOCK(clock), .NRST(nrst), .RX(rx),
		.TX(tx), .TX_READY(tx_ready), .PROG(prog), .PROG_STROBE(prog_strobe),
		.ERASE_STROBE(erase_strobe), .ERASE_ADDR(erase_addr), .ERASE_LEN(erase_len),
		.RUN_STROBE(run_strobe), .RUN_ADDR(run_addr), .SOFT_RESET(soft_reset));
	sldpe_host i_sldpe_host (.clk(clock), .rx(rx), .tx(tx), .tx_ready(tx_ready));

	// Monitor and hang limit.
	always @(posedge clock) begin
		cyc++;
		if (prog_strobe === 1'b1) pq.push_back(prog);
		if (erase_strobe === 1'b1) er_t = $time;
		if (run_strobe === 1'b1) run_t = $time;
		if (soft_reset === 1'b1) sr_t = $time;
		// The limit comes last so nothing runs after the verdict.
		if (cyc == 30000) begin
			fail_count++;
			give_verdict();
		end
	end

	task give_verdict;
		if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task ack(input logic [7:0] e);
		i_sldpe_host.get(b, t);
		chk("answer", e, b);
	endtask

	// Reset for three cycles; outputs must be quiet meanwhile.
	task do_reset;
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		chk("outputs", 0, {tx.valid, prog_strobe, erase_strobe, run_strobe, soft_reset});
		nrst <= 1'b1;
	endtask

	// Status query; a refused first copy must be answered again on resend.
	task automatic query(input logic [7:0] st, input bit nak);
		i_sldpe_host.pkt('{CMD_QUERY_RESULT}, 8'h00);
		ack(ACK_BYTE);
		i_sldpe_host.get(b, t);
		chk("length", LEN_SHORT, b);
		i_sldpe_host.get(b, t);
		chk("sum", st, b);
		i_sldpe_host.get(b, t);
		chk("status", st, b);
		i_sldpe_host.answer(nak ? NAK_BYTE : ACK_BYTE);
		if (nak) query(st, 1'b0);
	endtask

	// Data before any download programs nothing.
	task t_early;
		i_sldpe_host.pkt('{CMD_SEND_DATA, 8'h5A}, 8'h00);
		ack(ACK_BYTE);
		query(STAT_INVALID_CMD, 1'b0);
		chk("early writes", 0, pq.size());
	endtask

	// Ping, bad sum and an unknown code; the first query runs on a stalling link.
	task t_ping;
		i_sldpe_host.pkt('{CMD_PING}, 8'h00);
		ack(ACK_BYTE);
		i_sldpe_host.slow = 1'b1;
		query(STAT_SUCCESS, 1'b1);
		i_sldpe_host.slow = 1'b0;
		i_sldpe_host.pkt('{CMD_PING}, 8'h01);
		ack(NAK_BYTE);
		i_sldpe_host.pkt('{8'h30}, 8'h00);
		ack(ACK_BYTE);
		query(STAT_UNKNOWN_CMD, 1'b0);
	endtask

	// Download ten bytes at 0x1000, then two data packets with a refusal between.
	task t_load;
		logic [7:0] d[$];
		int i;
		pq.delete();
		i_sldpe_host.pkt('{CMD_DOWNLOAD, 0, 0, 8'h10, 0, 0, 0, 0, 8'h0A}, 8'h00);
		ack(ACK_BYTE);
		chk("erase addr", 32'h0000_1000, erase_addr);
		chk("erase len", 32'h0000_000A, erase_len);
		chk("erase first", 1, t >= er_t + EW * 20);
		query(STAT_SUCCESS, 1'b0);
		d = '{CMD_SEND_DATA};
		for (i = 0; i < 8; i++) d.push_back(8'h11 + 8'(i));
		i_sldpe_host.pkt(d, 8'h00);
		ack(ACK_BYTE);
		repeat (20) @(posedge clock);
		chk("writes", 8, pq.size());
		for (i = 0; i < 8; i++) chk("write", {32'h1000 + i, 8'h11 + 8'(i)}, pq[i]);
		query(STAT_SUCCESS, 1'b0);
		for (i = 1; i < 9; i++) d[i] = 8'h20 + 8'(i);
		i_sldpe_host.pkt(d, 8'h01);
		ack(NAK_BYTE);
		i_sldpe_host.pkt(d, 8'h00);
		ack(ACK_BYTE);
		repeat (20) @(posedge clock);
		chk("writes", 10, pq.size());
		chk("write", {32'h1008, 8'h21}, pq[8]);
		chk("write", {32'h1009, 8'h22}, pq[9]);
	endtask

	// Run after the answer, then a reset command after a fresh reset.
	task t_exit;
		i_sldpe_host.pkt('{CMD_RUN, 8'h12, 8'h34, 8'h56, 8'h78}, 8'h00);
		ack(ACK_BYTE);
		repeat (5) @(posedge clock);
		chk("run addr", 32'h1234_5678, run_addr);
		chk("run late", 1, run_t > t);
		do_reset();
		i_sldpe_host.pkt('{CMD_RESET}, 8'h00);
		ack(ACK_BYTE);
		repeat (5) @(posedge clock);
		chk("reset late", 1, sr_t > t);
	endtask

	initial begin
		do_reset();
		t_early();
		t_ping();
		t_load();
		t_exit();
		give_verdict();
	end
endmodule
`default_nettype wire
